// File: rtl/jcs_pkg.sv
package jcs_pkg;
  localparam int          IR_W               = 8;
  localparam int          SR_W               = 20;
  localparam logic [7:0]  CTRL_WORD_SELECT_I = 8'h13;
  localparam logic [7:0]  CTRL_READBACK_I    = 8'h14;
  localparam logic [7:0]  CTRL_RELEASE_I     = 8'h15;
  localparam logic [7:0]  DATA_WORD_I        = 8'h41;
  localparam logic [7:0]  ADDR_READBACK_I    = 8'h19;
  localparam logic [7:0]  MAILBOX_I          = 8'h61;
  localparam logic [7:0]  IR_RESET_VAL       = 8'hFF;
  localparam int          CB_RW              = 0;
  localparam int          CB_SUSPEND         = 8;
  localparam int          CB_UNDER_CTRL      = 9;
  localparam int          CB_ENABLE          = 10;
  localparam int          CB_POR             = 11;
  localparam logic [15:0] RESET_VECTOR       = 16'hFFFE;
  localparam logic [15:0] MAGIC_WORD         = 16'hA55A;
  localparam logic [15:0] NOP_OPCODE         = 16'h4303;
  localparam logic [15:0] MOVE_ADDRESS_OPCODE_MASK          = 16'hF0FF;
  localparam logic [15:0] MOVE_ADDRESS_OPCODE_PATTERN       = 16'h0080;
  localparam logic [2:0]  PIPE_PULSES        = 3'h5;
  localparam logic [4:0]  OFS_CONTROL        = 5'h00;
  localparam logic [4:0]  OFS_STATUS         = 5'h04;
  localparam logic [4:0]  OFS_PC             = 5'h08;
  localparam logic [4:0]  OFS_MAILBOX        = 5'h0C;
  localparam logic [4:0]  OFS_CTRLWORD       = 5'h10;
  localparam int          SW_POWER_DOWN      = 0;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jcs_tap_t;
  typedef enum logic [1:0] {PC_IDLE, PC_HIGH, PC_LOW, PC_NOP} jcs_pc_t;
endpackage : jcs_pkg

// File: rtl/jcs_sequencer.sv
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
module jcs_sequencer (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdoOe,
  input  wire logic        debugStepClock,
  input  wire logic        testPin,
  input  wire logic        resetPin,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             cpuRun,
  output logic             cpuStep,
  output logic             cpuPor,
  output logic             cpuReadSel,
  output logic             deviceReset,
  output logic             deepSleepMode,
  output logic             pinStateLock,
  output logic [19:0]      fetchAddr
);
  ////////////////////////////////////////////////////////////////////////////
  // cross-domain signals
  logic [1:0]  lockSyncTck;
  logic [1:0]  rstSyncTck;
  logic [1:0]  ctrlUnderTck;
  logic [2:0]  pcTglTck;
  logic        pcTgl;
  logic [19:0] pcSyncB;
  logic        underControlReg;
  logic        pinLockReg;
  logic [19:0] pcReg;
  logic        tapRstn;
  assign tapRstn = rstSyncTck[1] & ~lockSyncTck[1];
  ////////////////////////////////////////////////////////////////////////////
  // link domain: test access port
  jcs_pkg::jcs_tap_t    tapReg;
  jcs_pkg::jcs_tap_t    tapNext;
  logic [7:0]          irReg;
  logic [7:0]          irShiftReg;
  logic [19:0]         drReg;
  logic [15:0]         ctrlHold;
  logic [15:0]         dataHold;
  logic [15:0]         mboxHold;
  logic                ctrlTgl;
  logic                dataTgl;
  logic                relTgl;
  logic                mboxTgl;
  logic                wideDr;
  logic [19:0]         drNext;
  logic [19:0]         drCapture;
  logic                tdoNext;
  assign wideDr  = (irReg == jcs_pkg::ADDR_READBACK_I);
  assign drNext  = wideDr ? {tdi, drReg[19:1]} : {4'h0, tdi, drReg[15:1]};
  // bit 9 reflects the control state seen from the system side
  assign drCapture =
    (irReg == jcs_pkg::CTRL_READBACK_I) ?
      {4'h0, ctrlHold[15:10], ctrlUnderTck[1], ctrlHold[8:0]} :
    wideDr ? pcSyncB : 20'h00000;
  assign tdoNext = (tapReg == jcs_pkg::TAP_SHIFT_IR) ? irShiftReg[0] :
                   drReg[0];
  always_comb begin
    tapNext = tapReg;
    case (tapReg)
      jcs_pkg::TAP_RESET:    tapNext = tms ? jcs_pkg::TAP_RESET :
                                             jcs_pkg::TAP_IDLE;
      jcs_pkg::TAP_IDLE:     tapNext = tms ? jcs_pkg::TAP_SEL_DR :
                                             jcs_pkg::TAP_IDLE;
      jcs_pkg::TAP_SEL_DR:   tapNext = tms ? jcs_pkg::TAP_SEL_IR :
                                             jcs_pkg::TAP_CAP_DR;
      jcs_pkg::TAP_CAP_DR,
      jcs_pkg::TAP_SHIFT_DR: tapNext = tms ? jcs_pkg::TAP_EXIT1_DR :
                                             jcs_pkg::TAP_SHIFT_DR;
      jcs_pkg::TAP_EXIT1_DR: tapNext = tms ? jcs_pkg::TAP_UPD_DR :
                                             jcs_pkg::TAP_PAUSE_DR;
      jcs_pkg::TAP_PAUSE_DR: tapNext = tms ? jcs_pkg::TAP_EXIT2_DR :
                                             jcs_pkg::TAP_PAUSE_DR;
      jcs_pkg::TAP_EXIT2_DR: tapNext = tms ? jcs_pkg::TAP_UPD_DR :
                                             jcs_pkg::TAP_SHIFT_DR;
      jcs_pkg::TAP_UPD_DR,
      jcs_pkg::TAP_UPD_IR:   tapNext = tms ? jcs_pkg::TAP_SEL_DR :
                                             jcs_pkg::TAP_IDLE;
      jcs_pkg::TAP_SEL_IR:   tapNext = tms ? jcs_pkg::TAP_RESET :
                                             jcs_pkg::TAP_CAP_IR;
      jcs_pkg::TAP_CAP_IR,
      jcs_pkg::TAP_SHIFT_IR: tapNext = tms ? jcs_pkg::TAP_EXIT1_IR :
                                             jcs_pkg::TAP_SHIFT_IR;
      jcs_pkg::TAP_EXIT1_IR: tapNext = tms ? jcs_pkg::TAP_UPD_IR :
                                             jcs_pkg::TAP_PAUSE_IR;
      jcs_pkg::TAP_PAUSE_IR: tapNext = tms ? jcs_pkg::TAP_EXIT2_IR :
                                             jcs_pkg::TAP_PAUSE_IR;
      jcs_pkg::TAP_EXIT2_IR: tapNext = tms ? jcs_pkg::TAP_UPD_IR :
                                             jcs_pkg::TAP_SHIFT_IR;
      default:               tapNext = jcs_pkg::TAP_RESET;
    endcase
  end
  // reset and pin lock are pulled into the link domain; tap held while locked
  always_ff @(posedge tck) begin
    rstSyncTck   <= {rstSyncTck[0], rstn};
    lockSyncTck  <= {lockSyncTck[0], pinLockReg};
    ctrlUnderTck <= {ctrlUnderTck[0], underControlReg};
    pcTglTck     <= {pcTglTck[1:0], pcTgl};
    // counter copied only once its load flag has settled in this domain
    if (!rstSyncTck[1]) begin
      pcSyncB <= 20'h00000;
    end else if (pcTglTck[2] ^ pcTglTck[1]) begin
      pcSyncB <= pcReg;
    end
  end
  always_ff @(posedge tck) begin
    if (!tapRstn) begin
      tapReg     <= jcs_pkg::TAP_RESET;
      irReg      <= jcs_pkg::IR_RESET_VAL;
      irShiftReg <= 8'h00;
      drReg      <= 20'h00000;
    end else begin
      tapReg <= tapNext;
      case (tapReg)
        jcs_pkg::TAP_RESET:    irReg      <= jcs_pkg::IR_RESET_VAL;
        jcs_pkg::TAP_CAP_IR:   irShiftReg <= 8'h01;
        jcs_pkg::TAP_SHIFT_IR: irShiftReg <= {tdi, irShiftReg[7:1]};
        jcs_pkg::TAP_UPD_IR:   irReg      <= irShiftReg;
        jcs_pkg::TAP_CAP_DR:   drReg      <= drCapture;
        jcs_pkg::TAP_SHIFT_DR: drReg      <= drNext;
        default:               drReg      <= drReg;
      endcase
    end
  end
  // update events: hold word and toggle change on the same edge; toggle flags the event to system side
  always_ff @(posedge tck) begin
    // lock only parks the tap; toggles keep phase, so no false event
    if (!rstSyncTck[1]) begin
      ctrlHold <= 16'h0000;
      dataHold <= 16'h0000;
      mboxHold <= 16'h0000;
      ctrlTgl  <= 1'b0;
      dataTgl  <= 1'b0;
      relTgl   <= 1'b0;
      mboxTgl  <= 1'b0;
    end else if (tapReg == jcs_pkg::TAP_UPD_DR) begin
      if (irReg == jcs_pkg::CTRL_WORD_SELECT_I) begin
        ctrlHold <= drReg[15:0];
        ctrlTgl  <= ~ctrlTgl;
      end
      if (irReg == jcs_pkg::DATA_WORD_I) begin
        dataHold <= drReg[15:0];
        dataTgl  <= ~dataTgl;
      end
      if (irReg == jcs_pkg::MAILBOX_I) begin
        mboxHold <= drReg[15:0];
        mboxTgl  <= ~mboxTgl;
      end
    end else if (tapReg == jcs_pkg::TAP_UPD_IR &&
                 irShiftReg == jcs_pkg::CTRL_RELEASE_I) begin
      relTgl <= ~relTgl;
    end
  end
  always_ff @(negedge tck) begin
    if (!tapRstn) begin
      tdo   <= 1'b0;
      tdoOe <= 1'b0;
    end else begin
      tdo   <= tdoNext;
      tdoOe <= (tapReg == jcs_pkg::TAP_SHIFT_DR) ||
               (tapReg == jcs_pkg::TAP_SHIFT_IR);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // system domain: synchronisers and event decode
  logic [2:0]  ctrlSync;
  logic [2:0]  dataSync;
  logic [2:0]  relSync;
  logic [2:0]  mboxSync;
  logic [2:0]  stepSync;
  logic [1:0]  testSync;
  logic [2:0]  rpinSync;
  logic        ctrlEv;
  logic        dataEv;
  logic        relEv;
  logic        mboxEv;
  logic        stepRise;
  logic        stepFall;
  logic        unlockEv;
  assign ctrlEv   = ctrlSync[2] ^ ctrlSync[1];
  assign dataEv   = dataSync[2] ^ dataSync[1];
  assign relEv    = relSync[2] ^ relSync[1];
  assign mboxEv   = mboxSync[2] ^ mboxSync[1];
  assign stepRise = stepSync[1] & ~stepSync[2];
  assign stepFall = ~stepSync[1] & stepSync[2];
  // two-wire entry: reset pin rising while test pin held high
  assign unlockEv = testSync[1] & rpinSync[1] & ~rpinSync[2];
  always_ff @(posedge mclk) begin
    ctrlSync <= {ctrlSync[1:0], ctrlTgl};
    dataSync <= {dataSync[1:0], dataTgl};
    relSync  <= {relSync[1:0], relTgl};
    mboxSync <= {mboxSync[1:0], mboxTgl};
    stepSync <= {stepSync[1:0], debugStepClock};
    testSync <= {testSync[0], testPin};
    rpinSync <= {rpinSync[1:0], resetPin};
  end
  ////////////////////////////////////////////////////////////////////////////
  // cpu control state
  logic [15:0]         ctrlWordReg;
  logic [2:0]          pipeCountReg;
  logic                deepSleepReg;
  logic                devResetReg;
  logic                stepReg;
  logic                runReg;
  logic [15:0]         mboxReg;
  logic [3:0]          pcHighReg;
  logic [15:0]         pcLowReg;
  jcs_pkg::jcs_pc_t     pcStateReg;
  logic                fullEmu;
  logic                magicOk;
  logic                swPowerDown;
  assign fullEmu = underControlReg & ctrlWordReg[jcs_pkg::CB_SUSPEND] &
                   (pipeCountReg == jcs_pkg::PIPE_PULSES);
  assign magicOk = mboxEv & (mboxHold == jcs_pkg::MAGIC_WORD) &
                   ~rpinSync[1];
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrlWordReg     <= 16'h0000;
      underControlReg <= 1'b0;
      fetchAddr       <= {4'h0, jcs_pkg::RESET_VECTOR};
      deepSleepReg    <= 1'b0;
      devResetReg     <= 1'b0;
      mboxReg         <= 16'h0000;
    end else begin
      devResetReg <= magicOk;
      if (ctrlEv) begin
        ctrlWordReg <= ctrlHold;
      end
      if (mboxEv) begin
        mboxReg <= mboxHold;
      end
      // a loaded counter becomes the next fetch point
      if (pcStateReg == jcs_pkg::PC_NOP && stepFall) begin
        fetchAddr <= {pcHighReg, pcLowReg};
      end
      if (relEv) begin
        underControlReg <= 1'b0;
        fetchAddr       <= {4'h0, jcs_pkg::RESET_VECTOR};
      end else if (ctrlEv && ctrlHold[jcs_pkg::CB_ENABLE] && !pinLockReg) begin
        underControlReg <= 1'b1;
      end
      if (magicOk) begin
        deepSleepReg <= 1'b1;
      end else if (relEv) begin
        deepSleepReg <= 1'b0;
      end
    end
  end
  // pipeline drains only while not suspended and out of reset
  always_ff @(posedge mclk) begin
    if (!rstn || !underControlReg || ctrlWordReg[jcs_pkg::CB_POR]) begin
      pipeCountReg <= 3'h0;
    end else if (pcStateReg == jcs_pkg::PC_NOP && stepFall) begin
      pipeCountReg <= 3'h0;
    end else if (stepRise && !ctrlWordReg[jcs_pkg::CB_SUSPEND] &&
                 pipeCountReg != jcs_pkg::PIPE_PULSES) begin
      pipeCountReg <= pipeCountReg + 3'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stepReg <= 1'b0;
      runReg  <= 1'b0;
    end else begin
      stepReg <= stepRise & underControlReg;
      runReg  <= ~underControlReg & ~deepSleepReg & ~pinLockReg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // program counter load
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pcStateReg <= jcs_pkg::PC_IDLE;
      pcHighReg  <= 4'h0;
      pcLowReg   <= 16'h0000;
      pcReg      <= 20'h00000;
      pcTgl      <= 1'b0;
    end else begin
      case (pcStateReg)
        jcs_pkg::PC_IDLE: if (dataEv && fullEmu &&
            (dataHold & jcs_pkg::MOVE_ADDRESS_OPCODE_MASK) == jcs_pkg::MOVE_ADDRESS_OPCODE_PATTERN) begin
          pcHighReg  <= dataHold[11:8];
          pcStateReg <= jcs_pkg::PC_HIGH;
        end
        jcs_pkg::PC_HIGH: if (dataEv) begin
          pcLowReg   <= dataHold;
          pcStateReg <= jcs_pkg::PC_LOW;
        end
        jcs_pkg::PC_LOW: if (dataEv) begin
          pcStateReg <= (dataHold == jcs_pkg::NOP_OPCODE) ?
                        jcs_pkg::PC_NOP : jcs_pkg::PC_IDLE;
        end
        jcs_pkg::PC_NOP: if (stepFall) begin
          pcReg      <= {pcHighReg, pcLowReg};
          pcTgl      <= ~pcTgl;
          pcStateReg <= jcs_pkg::PC_IDLE;
        end
        default: pcStateReg <= jcs_pkg::PC_IDLE;
      endcase
      if (relEv) begin
        pcStateReg <= jcs_pkg::PC_IDLE;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // register bus slave, one wait state per access
  logic        ackReg;
  logic        selControl;
  logic        selStatus;
  logic        selPc;
  logic        selMailbox;
  logic        selCtrlWord;
  logic [31:0] readMux;
  assign selControl  = (avs_address == jcs_pkg::OFS_CONTROL);
  assign selStatus   = (avs_address == jcs_pkg::OFS_STATUS);
  assign selPc       = (avs_address == jcs_pkg::OFS_PC);
  assign selMailbox  = (avs_address == jcs_pkg::OFS_MAILBOX);
  assign selCtrlWord = (avs_address == jcs_pkg::OFS_CTRLWORD);
  assign swPowerDown = avs_write & ackReg & selControl &
                       avs_writedata[jcs_pkg::SW_POWER_DOWN];
  assign readMux =
    selControl  ? {31'h00000000, pinLockReg} :
    selStatus   ? {24'h000000, pipeCountReg, deepSleepReg, pinLockReg,
                   fullEmu, ctrlWordReg[jcs_pkg::CB_SUSPEND],
                   underControlReg} :
    selPc       ? {12'h000, pcReg} :
    selMailbox  ? {16'h0000, mboxReg} :
    selCtrlWord ? {16'h0000, ctrlWordReg} : 32'h00000000;
  assign avs_waitrequest = (avs_read | avs_write) & ~ackReg;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ackReg       <= 1'b0;
      avs_readdata <= 32'h00000000;
      pinLockReg   <= 1'b0;
    end else begin
      ackReg <= (avs_read | avs_write) & ~ackReg;
      if (avs_read && !ackReg) begin
        avs_readdata <= readMux;
      end
      // software entry into powered-down sleep wins over a link unlock
      if (swPowerDown) begin
        pinLockReg <= 1'b1;
      end else if (unlockEv) begin
        pinLockReg <= 1'b0;
      end
    end
  end
  assign cpuStep       = stepReg;
  assign cpuRun        = runReg;
  assign cpuPor        = ctrlWordReg[jcs_pkg::CB_POR] & underControlReg;
  assign cpuReadSel    = ctrlWordReg[jcs_pkg::CB_RW];
  assign deviceReset   = devResetReg;
  assign deepSleepMode = deepSleepReg;
  assign pinStateLock  = pinLockReg;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_magic;
    magicOk ##1 (devResetReg && deepSleepReg);
  endsequence
  property p_enable;
    @(posedge mclk) disable iff (!rstn)
      (ctrlEv && ctrlHold[jcs_pkg::CB_ENABLE] && !pinLockReg && !relEv)
      |=> underControlReg;
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable bit did not take control");
  property p_release;
    @(posedge mclk) disable iff (!rstn)
      relEv |=> (!underControlReg && fetchAddr == 20'h0FFFE);
  endproperty
  a_release: assert property (p_release)
    else $error("release did not restart at vector");
  property p_por_vector;
    @(posedge mclk) !rstn |=> (fetchAddr == 20'h0FFFE);
  endproperty
  a_por_vector: assert property (p_por_vector)
    else $error("reset did not load vector");
  property p_step;
    @(posedge mclk) disable iff (!rstn)
      stepRise |=> (cpuStep == $past(underControlReg)) ##1 !cpuStep;
  endproperty
  a_step: assert property (p_step)
    else $error("step pulse wrong");
  property p_magic;
    @(posedge mclk) disable iff (!rstn)
      magicOk |-> s_magic ##1 !devResetReg;
  endproperty
  a_magic: assert property (p_magic)
    else $error("magic entry failed");
  property p_sleep_norun;
    @(posedge mclk) disable iff (!rstn)
      deepSleepReg [*2] |-> !cpuRun;
  endproperty
  a_sleep_norun: assert property (p_sleep_norun)
    else $error("user code runs in deep sleep");
  property p_lock_block;
    @(posedge mclk) disable iff (!rstn)
      (pinLockReg && !underControlReg) |=> !underControlReg;
  endproperty
  a_lock_block: assert property (p_lock_block)
    else $error("control taken through pin lock");
  property p_pc_set;
    @(posedge mclk) disable iff (!rstn)
      (pcStateReg == jcs_pkg::PC_NOP && stepFall && !relEv)
      |=> (pcReg == {$past(pcHighReg), $past(pcLowReg)}) && !fullEmu;
  endproperty
  a_pc_set: assert property (p_pc_set)
    else $error("counter not set on falling step edge");
  property p_por_pipe;
    @(posedge mclk) disable iff (!rstn)
      (underControlReg && ctrlWordReg[jcs_pkg::CB_POR]) |=> !fullEmu;
  endproperty
  a_por_pipe: assert property (p_por_pipe)
    else $error("full emulation during reset");
  property p_rw;
    @(posedge mclk) disable iff (!rstn)
      ctrlEv |=> (cpuReadSel == $past(ctrlHold[0]));
  endproperty
  a_rw: assert property (p_rw)
    else $error("read/write select not taken");
endmodule : jcs_sequencer

// File: verification/jcs_host_model.sv
`timescale 1ns/100ps
module jcs_host_model (
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      debugStepClock,
  output logic      testPin,
  output logic      resetPin
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
    debugStepClock = 1'h1;
    testPin = 1'h0;
    resetPin = 1'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one 32 ns link period; tck stands still between frames
  task automatic clk(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #16;
    q = tdo;
    tck = 1'h1;
    #16;
    tck = 1'h0;
  endtask : clk
  task automatic tap_reset();
    logic b;
    repeat (5) clk(1'h1, 1'h0, b);
    clk(1'h0, 1'h0, b);
    #100;
  endtask : tap_reset
  // from idle, shift lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [19:0] v,
                      output logic [19:0] q);
    logic b;
    q = 20'h00000;
    clk(1'h1, 1'h0, b);
    if (ir) clk(1'h1, 1'h0, b);
    clk(1'h0, 1'h0, b);
    clk(1'h0, 1'h0, b);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, v[i], b);
      q[i] = b;
    end
    clk(1'h1, 1'h0, b);
    clk(1'h0, 1'h0, b);
    // released data line parks inverted, not at its last value
    tdi = ~tdi;
    // idle gap keeps updates well apart in the system domain
    #100;
  endtask : scan
  // levels held 25 ns, beyond the three-cycle synchroniser need
  task automatic step(input logic v);
    debugStepClock = v;
    #25;
  endtask : step
  task automatic pulse();
    step(1'h0);
    step(1'h1);
  endtask : pulse
  task automatic pins(input logic t, input logic r);
    testPin = t;
    resetPin = r;
    #50;
  endtask : pins
endmodule : jcs_host_model

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
  logic        mclk;
  logic        rstn;
  logic        tck, tms, tdi, tdo, tdoOe, stepClk, testPin, resetPin;
  logic [4:0]  avsAddress;
  logic        avsRead, avsWrite, avsWaitrequest;
  logic [31:0] avsWritedata, avsReaddata, d;
  logic        cpuRun, cpuStep, cpuPor, cpuReadSel;
  logic        deviceReset, deepSleepMode, pinStateLock;
  logic [19:0] fetchAddr, q;
  int          mismatches = 0;
  int          total_checks = 0;
  int          stepSeen = 0;
  int          resetSeen = 0;
  int          oeSeen = 0;
  int          n;
  jcs_sequencer i_dut (.mclk(mclk), .rstn(rstn), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .debugStepClock(stepClk),
    .testPin(testPin), .resetPin(resetPin), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .cpuRun(cpuRun), .cpuStep(cpuStep), .cpuPor(cpuPor),
    .cpuReadSel(cpuReadSel), .deviceReset(deviceReset),
    .deepSleepMode(deepSleepMode), .pinStateLock(pinStateLock),
    .fetchAddr(fetchAddr));
  jcs_host_model i_host (.tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
    .debugStepClock(stepClk), .testPin(testPin), .resetPin(resetPin));
  initial mclk = 1'h0;
  always #2.5 mclk = ~mclk;
  // one-cycle pulses are counted, not caught by polling
  always @(posedge mclk) begin
    if (cpuStep === 1'h1) stepSeen++;
    if (deviceReset === 1'h1) resetSeen++;
  end
  always @(posedge tck) begin
    if (tdoOe === 1'h1) oeSeen++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [4:0] a, input logic [31:0] v);
    @(posedge mclk);
    avsAddress   <= a;
    avsWritedata <= v;
    avsWrite     <= w;
    avsRead      <= ~w;
    // only the watchdog ends a wait that never answers
    do begin
      @(posedge mclk);
    end while (avsWaitrequest !== 1'h0);
    d = avsReaddata;
    avsWrite <= 1'h0;
    avsRead  <= 1'h0;
  endtask : bus
  task ir(input logic [7:0] c);
    i_host.scan(1'h1, 8, {12'h000, c}, q);
  endtask : ir
  task dr(input logic [15:0] v);
    i_host.scan(1'h0, 16, {4'h0, v}, q);
  endtask : dr
  task ctl(input logic [15:0] v);
    ir(jcs_pkg::CTRL_WORD_SELECT_I);
    dr(v);
  endtask : ctl
  task tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'h0;
    avsAddress = 5'h00;
    avsRead = 1'h0;
    avsWrite = 1'h0;
    avsWritedata = 32'h0;
    fork
      begin
        repeat (20) @(posedge mclk);
        rstn <= 1'h1;
      end
      i_host.tap_reset();
    join
    i_host.tap_reset();
    chk(32'(fetchAddr), 32'h0FFFE);
    chk(32'(cpuRun), 32'h1);
    bus(1'h0, 5'h14, 32'h0);
    chk(d, 32'h0);
    // poll until the readback shows the CPU held
    n = 0;
    do begin
      ctl(16'h1501);
      ir(jcs_pkg::CTRL_READBACK_I);
      dr(16'h0000);
      n++;
    end while (q[9] !== 1'h1 && n < 4);
    chk(32'(q[9]), 32'h1);
    chk(32'(cpuRun), 32'h0);
    chk(32'(cpuReadSel), 32'h1);
    i_host.pulse();
    ctl(16'h0C01);
    chk(32'(cpuPor), 32'h1);
    ctl(16'h0401);
    chk(32'(cpuPor), 32'h0);
    repeat (5) i_host.pulse();
    ctl(16'h0501);
    chk(32'(stepSeen), 32'h6);
    bus(1'h0, jcs_pkg::OFS_STATUS, 32'h0);
    chk(32'(d[2]), 32'h1);
    i_host.step(1'h0);
    ir(jcs_pkg::DATA_WORD_I);
    i_host.step(1'h1);
    dr(16'h0380);
    ctl(16'h1400);
    chk(32'(cpuReadSel), 32'h0);
    ir(jcs_pkg::DATA_WORD_I);
    i_host.pulse();
    dr(16'h1234);
    i_host.pulse();
    dr(jcs_pkg::NOP_OPCODE);
    i_host.step(1'h0);
    ir(jcs_pkg::ADDR_READBACK_I);
    oeSeen = 0;
    i_host.scan(1'h0, 20, 20'h00000, q);
    chk(32'(q), 32'h31234);
    chk(32'(oeSeen), 32'h14);
    chk(32'(fetchAddr), 32'h31234);
    bus(1'h0, jcs_pkg::OFS_PC, 32'h0);
    chk(d, 32'h31234);
    bus(1'h0, jcs_pkg::OFS_STATUS, 32'h0);
    chk(32'(d[2]), 32'h0);
    i_host.step(1'h1);
    chk(32'(stepSeen), 32'hA);
    // release only once the counter load is over
    ctl(16'h2C01);
    dr(16'h2401);
    ir(jcs_pkg::CTRL_RELEASE_I);
    #200;
    chk(32'(fetchAddr), 32'h0FFFE);
    chk(32'(cpuRun), 32'h1);
    bus(1'h1, jcs_pkg::OFS_CONTROL, 32'h1);
    bus(1'h0, jcs_pkg::OFS_CONTROL, 32'h0);
    chk(32'(d[0]), 32'h1);
    chk(32'(pinStateLock), 32'h1);
    ctl(16'h1501);
    bus(1'h0, jcs_pkg::OFS_STATUS, 32'h0);
    chk(32'(d[0]), 32'h0);
    bus(1'h1, jcs_pkg::OFS_CONTROL, 32'h0);
    i_host.pins(1'h1, 1'h0);
    i_host.pins(1'h1, 1'h1);
    i_host.pins(1'h0, 1'h1);
    chk(32'(pinStateLock), 32'h0);
    i_host.tap_reset();
    // the word alone, without reset held, must be ignored
    ir(jcs_pkg::MAILBOX_I);
    dr(jcs_pkg::MAGIC_WORD);
    #200;
    chk(32'(deepSleepMode), 32'h0);
    i_host.pins(1'h0, 1'h0);
    dr(jcs_pkg::MAGIC_WORD);
    #200;
    chk(32'(resetSeen), 32'h1);
    chk(32'(deepSleepMode), 32'h1);
    bus(1'h0, jcs_pkg::OFS_MAILBOX, 32'h0);
    chk(d, 32'h0000A55A);
    i_host.pins(1'h0, 1'h1);
    chk(32'(cpuRun), 32'h0);
    ir(jcs_pkg::CTRL_RELEASE_I);
    #200;
    chk(32'(deepSleepMode), 32'h0);
    tally_and_finish();
  end
endmodule : tb
